/* File: dv/isb_bank_chk.sv */
// Checker for the bank bus handshake and interrupt output.
// Assumes a bind to isb_bank; one clock, sync reset.
module isb_bank_chk
(
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [3:0]  alarm_one_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// No write sampled in two cycles running
	sequence s_nowr;
		!(cyc_i && we_i) ##1 !(cyc_i && we_i) && irq_o;
	endsequence
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_dat_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
		else $error("read data moved");
	a_irq_quiet: assert property ($fell(rst_i) |-> !irq_o [*3])
		else $error("irq after reset");
	a_irq_drop: assert property ($fell(irq_o) |-> $past(ack_o && we_i))
		else $error("irq fell alone");
	a_irq_hold: assert property (s_nowr |=> irq_o)
		else $error("irq lost");
	a_irq_rise: assert property ($rose(irq_o) |-> $past(ack_o)
		|| $past(|alarm_one_i) || $past(|alarm_one_i, 2))
		else $error("irq rose alone");
endmodule

/* File: dv/isb_host.sv */
// Classic Wishbone master standing in for the host.
// Assumes stb follows cyc and every byte lane is on.
module isb_host
(
	input  wire         clk_i,
	input  wire         ack_i,
	input  wire  [31:0] rdat_i,
	output logic        cyc_o = 1'b0,
	output logic        we_o = 1'b0,
	output logic [17:0] adr_o = 18'h0,
	output logic [31:0] dat_o = 32'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Request holds until ack; gives up after 16 edges
	task xfer(input logic w, input logic [15:0] idx,
		input logic [31:0] d, output logic [31:0] rd, output logic ok);
		ok = 1'b0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		dat_o <= d;
		for (int n = 0; n < 16 && ok !== 1'b1; n++)
		begin
			@(posedge clk_i);
			ok = ack_i;
			rd = rdat_i;
		end
		cyc_o <= 1'b0;
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the interrupt status and mask bank.
// Assumes the host model owns the bus; sources driven here.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc, we, ack, irq, ok;
	logic [17:0] adr;
	logic [31:0] wd, dat, rd;
	logic [3:0] al = 4'h0;
	logic [8:0] s = 9'h0;
	int mismatches = 0, tests_run = 0, i;
	// Source bits, register index, expected read
	logic [56:0] rows [4] = '{{9'h180, 16'h1980, 32'h1080},
		{9'h07f, 16'h1981, 32'h7360}, {9'h0a5, 16'h1980, 32'h80},
		{9'h0a5, 16'h1981, 32'h2120}};
	isb_host h (.clk_i(clk_i), .ack_i(ack), .rdat_i(dat), .cyc_o(cyc),
		.we_o(we), .adr_o(adr), .dat_o(wd));
	isb_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat),
		.ack_o(ack), .alarm_one_i(al), .host_iface_error_i(s[8]),
		.boot_complete_i(s[7]), .processor_clock_short_i(s[6]),
		.async_clock_short_i(s[5]), .system_clock_short_i(s[4]),
		.freq_loop_two_locked_i(s[3]), .freq_loop_one_locked_i(s[2]),
		.freq_loop_two_ref_missing_i(s[1]),
		.freq_loop_one_ref_missing_i(s[0]), .irq_o(irq));
	task complete_run();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [15:0] x, input logic [31:0] d);
		h.xfer(w, x, d, rd, ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			complete_run();
		end
	endtask
	task rc(input logic [15:0] x, input logic [31:0] e);
		bus(1'b0, x, 32'h0);
		chk(rd, e);
	endtask
	initial forever #5 clk_i = ~clk_i;
	// Register tour, then edge flags, masking and clearing
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(16'h1923, 32'h0);
		rc(16'h1963, 32'hf);
		rc(16'h1980, 32'h0);
		rc(16'h1981, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			s <= rows[i][56:48];
			rc(rows[i][47:32], rows[i][31:0]);
		end
		s <= 9'h080;
		for (i = 0; i < 9 && rd[7] !== 1'b1; i++) bus(1'b0, 16'h1980, 0);
		chk({31'h0, rd[7]}, 32'h1);
		al <= 4'h5;
		rc(16'h1923, 32'h5);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 16'h1963, 32'hb);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 16'h1923, 32'h0);
		rc(16'h1923, 32'h5);
		bus(1'b1, 16'h1923, 32'h4);
		rc(16'h1923, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 16'h1981, 32'hffff);
		rc(16'h1981, 32'h0);
		rc(16'h1950, 32'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(16'h1963, 32'hf);
		rc(16'h1923, 32'h0);
		complete_run();
	end
endmodule
bind isb_bank isb_bank_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .alarm_one_i(alarm_one_i),
	.dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

/* File: logic/isb_bank.v */
// Interrupt status and mask bank with a classic Wishbone slave.
// Assumes status sources are synchronous to clk_i; reset is synchronous.
`include "isb_consts.vh"

module isb_bank
(
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [17:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Event and status sources
	input  wire [3:0]  alarm_one_i,
	input  wire        host_iface_error_i,
	input  wire        boot_complete_i,
	input  wire        processor_clock_short_i,
	input  wire        async_clock_short_i,
	input  wire        system_clock_short_i,
	input  wire        freq_loop_two_locked_i,
	input  wire        freq_loop_one_locked_i,
	input  wire        freq_loop_two_ref_missing_i,
	input  wire        freq_loop_one_ref_missing_i,
	// Combined interrupt
	output reg         irq_o
);
	reg  [3:0]  irq_mask_bit_ff;
	reg  [15:0] raw_iface_ff;
	reg  [15:0] raw_clocks_ff;
	reg  [31:0] nxt_dat;
	reg  [3:0]  flag_clear;
	wire [3:0]  alarm_flags;
	wire [15:0] word_idx;
	wire        req;
	wire        wr_lo;
	wire        nxt_irq;

	// Index is the word address; upper bits beyond the map must be zero
	assign word_idx = {adr_i[17:2]};
	assign req      = cyc_i && stb_i && !ack_o;
	assign wr_lo    = req && we_i && sel_i[0];

	// Write-one-to-clear strobes, only on the accepting cycle
	always @*
	begin
		flag_clear = 4'h0;
		if (wr_lo && word_idx == `ISB_IDX_ALARM_FLAGS)
			flag_clear = dat_i[3:0];
	end

	isb_edge_flags u_flags
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.alarm_i (alarm_one_i),
		.clear_i (flag_clear),
		.flag_o  (alarm_flags)
	);

	// Mask bits; only the alarm bits exist in this bank slice
	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_bit_ff <= `ISB_MASK_RST;
		else if (wr_lo && word_idx == `ISB_IDX_MASK_ALARM)
			irq_mask_bit_ff <= dat_i[3:0];
	end

	// Raw status capture; registered so reads see a stable value
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			raw_iface_ff  <= `ISB_RAW_RST;
			raw_clocks_ff <= `ISB_RAW_RST;
		end
		else
		begin
			raw_iface_ff  <= `ISB_RAW_RST;
			raw_clocks_ff <= `ISB_RAW_RST;
			raw_iface_ff[`ISB_BIT_IFACE_ERR]    <= host_iface_error_i;
			raw_iface_ff[`ISB_BIT_BOOT_DONE]    <= boot_complete_i;
			raw_clocks_ff[`ISB_BIT_PCLK_SHORT]  <=
				processor_clock_short_i;
			raw_clocks_ff[`ISB_BIT_ACLK_SHORT]  <=
				async_clock_short_i;
			raw_clocks_ff[`ISB_BIT_SCLK_SHORT]  <=
				system_clock_short_i;
			raw_clocks_ff[`ISB_BIT_FL2_LOCK]    <=
				freq_loop_two_locked_i;
			raw_clocks_ff[`ISB_BIT_FL1_LOCK]    <=
				freq_loop_one_locked_i;
			raw_clocks_ff[`ISB_BIT_FL2_REFLOST] <=
				freq_loop_two_ref_missing_i;
			raw_clocks_ff[`ISB_BIT_FL1_REFLOST] <=
				freq_loop_one_ref_missing_i;
		end
	end

	// Read mux; unmapped and unused mask words read as zero
	always @*
	begin
		nxt_dat = 32'h0000_0000;
		case (word_idx)
			`ISB_IDX_ALARM_FLAGS: nxt_dat[3:0]  = alarm_flags;
			`ISB_IDX_MASK_ALARM:  nxt_dat[3:0]  = irq_mask_bit_ff;
			`ISB_IDX_RAW_IFACE:   nxt_dat[15:0] = raw_iface_ff;
			`ISB_IDX_RAW_CLOCKS:  nxt_dat[15:0] = raw_clocks_ff;
			default:              nxt_dat = 32'h0000_0000;
		endcase
	end

	// Single-wait-state ack, dropped the cycle after it was given
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= req;
			if (req && !we_i)
				dat_o <= nxt_dat;
		end
	end

	// Combined request from unmasked flags
	assign nxt_irq = |(alarm_flags & ~irq_mask_bit_ff);

	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= nxt_irq;
	end
endmodule

/* File: logic/isb_consts.vh */
// Constants for the second-bank interrupt status and mask block.
// Assumes word-indexed Wishbone addressing: byte address = 4 * index.
`ifndef ISB_CONSTS_VH
`define ISB_CONSTS_VH

// Register indices
`define ISB_IDX_ALARM_FLAGS   16'h1923
`define ISB_IDX_MASK_FIRST    16'h1940
`define ISB_IDX_MASK_LAST     16'h1963
`define ISB_IDX_MASK_ALARM    16'h1963
`define ISB_IDX_RAW_IFACE     16'h1980
`define ISB_IDX_RAW_CLOCKS    16'h1981

// Field positions, raw status 1
`define ISB_BIT_IFACE_ERR     12
`define ISB_BIT_BOOT_DONE     7
// Field positions, raw status 2
`define ISB_BIT_PCLK_SHORT    14
`define ISB_BIT_ACLK_SHORT    13
`define ISB_BIT_SCLK_SHORT    12
`define ISB_BIT_FL2_LOCK      9
`define ISB_BIT_FL1_LOCK      8
`define ISB_BIT_FL2_REFLOST   6
`define ISB_BIT_FL1_REFLOST   5

// Reset values and alarm channel count
`define ISB_FLAGS_RST         4'h0
`define ISB_MASK_RST          4'hf
`define ISB_RAW_RST           16'h0000
`define ISB_NUM_ALARM         4

`endif

/* File: logic/isb_edge_flags.v */
// Rising-edge catchers with sticky write-one-to-clear flags.
// Assumes alarm inputs are synchronous to clk_i.
`include "isb_consts.vh"

module isb_edge_flags
(
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire [3:0] alarm_i,
	input  wire [3:0] clear_i,
	output wire [3:0] flag_o
);
	reg [3:0] prev_ff;
	reg [3:0] flag_ff;

	assign flag_o = flag_ff;

	// One edge catcher and flag per alarm channel
	genvar g;
	generate
		for (g = 0; g < `ISB_NUM_ALARM; g = g + 1)
		begin : ch
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					// Track the pin in reset: a level held through reset
					// must not look like a fresh edge afterwards
					prev_ff[g] <= alarm_i[g];
					flag_ff[g] <= 1'b0;
				end
				else
				begin
					prev_ff[g] <= alarm_i[g];
					// Set wins over a same-cycle clear
					if (alarm_i[g] && !prev_ff[g])
						flag_ff[g] <= 1'b1;
					else if (clear_i[g])
						flag_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
